// File: external_data_memory_interface.sv
// external data memory interface: register file, address decode, on-chip
// data memory and the pin side of off-chip cycles
// assumes the core holds a move request stable until done and stalls meanwhile
//
// Summary of operation
// - non-multiplexed: address and data on separate pins
// - mode 00: all moves on-chip, 4k fold
// - 8-bit address: page high, pointer low
// - 16-bit address from data pointer
// - mode 01: below 4k on-chip, else off
// - mode 01 8-bit: page decides location
// - mode 01 8-bit off-chip: upper undriven
// - split 16-bit: pointer decides, all lines driven
// - mode 10: below 4k on-chip, else off
// - mode 10 8-bit: page drives upper byte
// - mode 11: every move off-chip
// - mode 11 8-bit: page ignored, upper undriven
// - setup field gives 0-3 cycles
// - strobe lasts width field plus one
// - hold field gives 0-3 cycles
// - timing register resets to all ones
// - transfer takes programmed cycles plus four
// - multiplexed latch phase adds two or more
// - latch widths from config low bits
// - config 101/110/111: non-multiplexed cycles
// - config 001/010/011: multiplexed cycles
// - latch high and low: field plus one
// - low address on shared pins while latching
// - pins owned only during off-chip move
`timescale 1ns/1ps
module external_data_memory_interface (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_we,
  output logic      [7:0] sfr_rdata,
  input  wire logic       xmove_req,
  input  wire logic       xmove_wr,
  input  wire logic       xmove_is16,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0] indirect_pointer_register,
  input  wire logic [7:0] xmove_wdata,
  output logic            xmove_busy,
  output logic            xmove_done,
  output logic      [7:0] xmove_rdata,
  output logic            port_select,
  output logic            pins_owned,
  output logic      [7:0] addr_hi_out,
  output logic            addr_hi_oe,
  output logic      [7:0] addr_lo_out,
  output logic            addr_lo_oe,
  output logic      [7:0] ad_out,
  output logic            ad_oe,
  input  wire logic [7:0] ad_in,
  output logic            ale,
  output logic            rd_n,
  output logic            wr_n
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] external_bus_timing_control_reg;
  logic [7:0] xdata_memory_page_select_reg;
  logic [7:0] external_memory_config_reg;
  logic [7:0] sfr_rdata_reg;

  logic wr_timing;
  logic wr_page;
  logic wr_config;
  logic [7:0] rd_value;

  assign wr_timing = sfr_we && (sfr_addr == xmem_pkg::TIMING_ADDR);
  assign wr_page   = sfr_we && (sfr_addr == xmem_pkg::PAGE_ADDR);
  assign wr_config = sfr_we && (sfr_addr == xmem_pkg::CONFIG_ADDR);

  // unmapped addresses read as zero
  assign rd_value =
    (sfr_addr == xmem_pkg::TIMING_ADDR) ? external_bus_timing_control_reg :
    (sfr_addr == xmem_pkg::PAGE_ADDR)   ? xdata_memory_page_select_reg :
    (sfr_addr == xmem_pkg::CONFIG_ADDR) ? external_memory_config_reg : 8'h00;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      external_bus_timing_control_reg <= xmem_pkg::TIMING_RESET;
      xdata_memory_page_select_reg            <= xmem_pkg::PAGE_RESET;
      external_memory_config_reg      <= xmem_pkg::CONFIG_RESET;
    end else begin
      if (wr_timing) begin
        external_bus_timing_control_reg <= sfr_wdata;
      end
      if (wr_page) begin
        xdata_memory_page_select_reg <= sfr_wdata;
      end
      if (wr_config) begin
        external_memory_config_reg <= sfr_wdata & xmem_pkg::CONFIG_MASK;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata_reg <= 8'h00;
    end else begin
      sfr_rdata_reg <= rd_value;
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  logic [1:0] address_setup_field;
  logic [3:0] strobe_width_field;
  logic [1:0] address_hold_field;
  logic       mux_mode_select;
  logic [1:0] memory_mode_select;
  logic [1:0] latch_pulse_width_field;
  logic       muxed;

  assign address_setup_field =
    external_bus_timing_control_reg[xmem_pkg::SETUP_MSB:xmem_pkg::SETUP_LSB];
  assign strobe_width_field =
    external_bus_timing_control_reg[xmem_pkg::WIDTH_MSB:xmem_pkg::WIDTH_LSB];
  assign address_hold_field =
    external_bus_timing_control_reg[xmem_pkg::HOLD_MSB:xmem_pkg::HOLD_LSB];
  assign mux_mode_select    = external_memory_config_reg[xmem_pkg::MUXSEL_BIT];
  assign memory_mode_select =
    external_memory_config_reg[xmem_pkg::MODE_MSB:xmem_pkg::MODE_LSB];
  assign latch_pulse_width_field =
    external_memory_config_reg[xmem_pkg::ALE_MSB:xmem_pkg::ALE_LSB];
  // select bit set means separate pins
  // select bit clear means shared pins
  assign muxed = !mux_mode_select;

  // ----------------------------------------
  // address and location decode
  // ----------------------------------------
  logic [15:0] eff_addr;
  logic        above_onchip;
  logic        split_mode;
  logic        off_dec;
  logic        hi_dec;

  assign eff_addr     = xmove_is16 ? data_pointer
                                   : {xdata_memory_page_select_reg, indirect_pointer_register};
  assign above_onchip = |eff_addr[15:xmem_pkg::ONCHIP_AW];
  assign split_mode   = (memory_mode_select == xmem_pkg::MODE_SPLIT_NB) ||
                        (memory_mode_select == xmem_pkg::MODE_SPLIT_BS);
  assign off_dec = (memory_mode_select == xmem_pkg::MODE_EXTERNAL) ||
                   (split_mode && above_onchip);
  assign hi_dec = xmove_is16 || (memory_mode_select == xmem_pkg::MODE_SPLIT_BS);

  // ----------------------------------------
  // request acceptance
  // ----------------------------------------
  logic        busy_reg;
  logic        accept;
  logic        go_off;
  logic        go_on;
  logic [15:0] op_addr_reg;
  logic        op_wr_reg;
  logic        op_hi_reg;
  logic [7:0]  op_wdata_reg;

  assign accept = xmove_req && !busy_reg;
  assign go_off = accept && off_dec;
  assign go_on  = accept && !off_dec;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_addr_reg  <= 16'h0000;
      op_wr_reg    <= 1'b0;
      op_hi_reg    <= 1'b0;
      op_wdata_reg <= 8'h00;
    end else if (go_off) begin
      op_addr_reg  <= eff_addr;
      op_wr_reg    <= xmove_wr;
      op_hi_reg    <= hi_dec;
      op_wdata_reg <= xmove_wdata;
    end
  end

  // ----------------------------------------
  // on-chip data memory
  // ----------------------------------------
  logic [7:0] onchip_mem [xmem_pkg::ONCHIP_DEPTH];
  logic [xmem_pkg::ONCHIP_AW-1:0] onchip_idx;

  assign onchip_idx = eff_addr[xmem_pkg::ONCHIP_AW-1:0];

  // no reset: contents are undefined after power-up, like any ram
  always_ff @(posedge clk) begin
    if (go_on && xmove_wr) begin
      onchip_mem[onchip_idx] <= xmove_wdata;
    end
  end

  // ----------------------------------------
  // off-chip cycle sequencer
  // ----------------------------------------
  xmem_seq_if sq ();

  assign sq.start = go_off;
  assign sq.mux   = muxed;
  assign sq.setup = address_setup_field;
  assign sq.width = strobe_width_field;
  assign sq.hold  = address_hold_field;
  assign sq.ale_w = latch_pulse_width_field;

  xmem_sequencer u_seq (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sq      (sq)
  );

  // ----------------------------------------
  // pin next values
  // ----------------------------------------
  logic       owned_nx;
  logic       ad_addr_ph;
  logic       ad_oe_nx;
  logic [7:0] ad_out_nx;

  assign owned_nx   = sq.busy;
  assign ad_addr_ph = muxed && sq.addr_phase;
  assign ad_oe_nx   = owned_nx && (ad_addr_ph || op_wr_reg);
  assign ad_out_nx  = ad_addr_ph ? op_addr_reg[7:0] : op_wdata_reg;

  // ----------------------------------------
  // pin output flops
  // ----------------------------------------
  // everything reaches the pins one cycle after the sequencer phase,
  // so the relative timing of all pins is preserved
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_owned  <= 1'b0;
      addr_hi_out <= 8'h00;
      addr_hi_oe  <= 1'b0;
      addr_lo_out <= 8'h00;
      addr_lo_oe  <= 1'b0;
      ad_out      <= 8'h00;
      ad_oe       <= 1'b0;
      ale         <= 1'b0;
      rd_n        <= 1'b1;
      wr_n        <= 1'b1;
    end else begin
      pins_owned  <= owned_nx;
      addr_hi_out <= owned_nx ? op_addr_reg[15:8] : 8'h00;
      addr_hi_oe  <= owned_nx && op_hi_reg;
      addr_lo_out <= (owned_nx && !muxed) ? op_addr_reg[7:0] : 8'h00;
      addr_lo_oe  <= owned_nx && !muxed;
      ad_out      <= ad_oe_nx ? ad_out_nx : 8'h00;
      ad_oe       <= ad_oe_nx;
      ale         <= sq.ale_phase;
      rd_n        <= !(sq.strobe && !op_wr_reg);
      wr_n        <= !(sq.strobe && op_wr_reg);
    end
  end

  // ----------------------------------------
  // read data capture
  // ----------------------------------------
  logic [7:0] ad_s1_reg;
  logic [7:0] ad_s2_reg;
  logic [xmem_pkg::CAP_DELAY-1:0] cap_pipe_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ad_s1_reg <= 8'h00;
      ad_s2_reg <= 8'h00;
    end else begin
      ad_s1_reg <= ad_in;
      ad_s2_reg <= ad_s1_reg;
    end
  end

  // sample at strobe end
  // the pipe lines the strobe end up with the synchronised pin value,
  // so the byte taken is the one present in the last strobe cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_pipe_reg <= '0;
    end else begin
      cap_pipe_reg <= {cap_pipe_reg[xmem_pkg::CAP_DELAY-2:0], sq.stb_end && !op_wr_reg};
    end
  end

  // ----------------------------------------
  // completion to the core
  // ----------------------------------------
  logic last_d_reg;
  logic done_reg;
  logic [7:0] rdata_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_d_reg <= 1'b0;
      done_reg   <= 1'b0;
      busy_reg   <= 1'b0;
    end else begin
      last_d_reg <= sq.last;
      done_reg   <= go_on || last_d_reg;
      if (go_off) begin
        busy_reg <= 1'b1;
      end else if (last_d_reg) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (go_on && !xmove_wr) begin
      rdata_reg <= onchip_mem[onchip_idx];
    end else if (cap_pipe_reg[xmem_pkg::CAP_DELAY-1]) begin
      rdata_reg <= ad_s2_reg;
    end
  end

  assign sfr_rdata   = sfr_rdata_reg;
  assign xmove_busy  = busy_reg;
  assign xmove_done  = done_reg;
  assign xmove_rdata = rdata_reg;
  assign port_select = external_memory_config_reg[xmem_pkg::PORTSEL_BIT];

endmodule

// File: xmem_pkg.sv
// constants shared by the external data memory interface and its sequencer
// assumes a single system clock; offsets are special-function register addresses
package xmem_pkg;

  // ----------------------------------------
  // register addresses and reset values
  // ----------------------------------------
  localparam logic [7:0] TIMING_ADDR  = 8'ha1;
  localparam logic [7:0] PAGE_ADDR    = 8'ha2;
  localparam logic [7:0] CONFIG_ADDR  = 8'ha3;
  localparam logic [7:0] TIMING_RESET = 8'hff;
  localparam logic [7:0] PAGE_RESET   = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h03;
  // bits 7-6 of the configuration register read as zero
  localparam logic [7:0] CONFIG_MASK  = 8'h3f;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SETUP_MSB   = 7;
  localparam int SETUP_LSB   = 6;
  localparam int WIDTH_MSB   = 5;
  localparam int WIDTH_LSB   = 2;
  localparam int HOLD_MSB    = 1;
  localparam int HOLD_LSB    = 0;
  localparam int PORTSEL_BIT = 5;
  localparam int MUXSEL_BIT  = 4;
  localparam int MODE_MSB    = 3;
  localparam int MODE_LSB    = 2;
  localparam int ALE_MSB     = 1;
  localparam int ALE_LSB     = 0;

  // ----------------------------------------
  // memory modes and sizes
  // ----------------------------------------
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT_NB = 2'h1;
  localparam logic [1:0] MODE_SPLIT_BS = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;
  localparam int ONCHIP_AW    = 12;
  localparam int ONCHIP_DEPTH = 4096;

  // ----------------------------------------
  // timing counts in system clock cycles
  // ----------------------------------------
  // lead and tail are two cycles each: the four fixed cycles of a transfer
  localparam logic [3:0] LEAD_LOAD = 4'h1;
  localparam logic [3:0] TAIL_LOAD = 4'h1;
  // pin output flop plus two synchroniser flops
  localparam int CAP_DELAY = 3;

endpackage

// File: xmem_seq_if.sv
// carries timing settings to the off-chip cycle sequencer and its phases back
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface xmem_seq_if;
  logic       start;
  logic       mux;
  logic [1:0] setup;
  logic [3:0] width;
  logic [1:0] hold;
  logic [1:0] ale_w;
  logic       busy;
  logic       addr_phase;
  logic       ale_phase;
  logic       strobe;
  logic       stb_end;
  logic       last;

  modport seq (
    input  start, mux, setup, width, hold, ale_w,
    output busy, addr_phase, ale_phase, strobe, stb_end, last
  );
  modport ctl (
    output start, mux, setup, width, hold, ale_w,
    input  busy, addr_phase, ale_phase, strobe, stb_end, last
  );
endinterface

// File: xmem_sequencer.sv
// phase sequencer for one off-chip cycle: lead, latch pulse, setup, strobe,
// hold, tail; settings must stay stable while a cycle runs
`timescale 1ns/1ps
module xmem_sequencer (
  input  wire logic clk,
  input  wire logic sys_rst,
  xmem_seq_if.seq   sq
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_LEAD, ST_ALE_HI, ST_ALE_LO, ST_SETUP, ST_STROBE, ST_HOLD, ST_TAIL
  } seq_state_e;

  seq_state_e state_reg;
  seq_state_e state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       cnt_zero;

  assign cnt_zero      = (cnt_reg == 4'h0);
  assign sq.busy       = (state_reg != ST_IDLE);
  assign sq.addr_phase = (state_reg == ST_LEAD) || (state_reg == ST_ALE_HI);
  assign sq.ale_phase  = (state_reg == ST_ALE_HI);
  assign sq.strobe     = (state_reg == ST_STROBE);
  assign sq.stb_end    = sq.strobe && cnt_zero;
  assign sq.last       = (state_reg == ST_TAIL) && cnt_zero;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_zero ? 4'h0 : cnt_reg - 4'h1;
    unique case (state_reg)
      ST_IDLE: begin
        if (sq.start) begin
          state_next = ST_LEAD;
          cnt_next   = xmem_pkg::LEAD_LOAD;
        end
      end
      ST_LEAD, ST_ALE_HI, ST_ALE_LO: begin
        if (cnt_zero) begin
          if (state_reg == ST_LEAD && sq.mux) begin
            state_next = ST_ALE_HI;
            cnt_next   = {2'h0, sq.ale_w};
          end else if (state_reg == ST_ALE_HI) begin
            state_next = ST_ALE_LO;
            cnt_next   = {2'h0, sq.ale_w};
          end else if (sq.setup != 2'h0) begin
            state_next = ST_SETUP;
            cnt_next   = {2'h0, sq.setup - 2'h1};
          end else begin
            state_next = ST_STROBE;
            cnt_next   = sq.width;
          end
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          state_next = ST_STROBE;
          cnt_next   = sq.width;
        end
      end
      ST_STROBE: begin
        if (cnt_zero) begin
          if (sq.hold != 2'h0) begin
            state_next = ST_HOLD;
            cnt_next   = {2'h0, sq.hold - 2'h1};
          end else begin
            state_next = ST_TAIL;
            cnt_next   = xmem_pkg::TAIL_LOAD;
          end
        end
      end
      ST_HOLD: begin
        if (cnt_zero) begin
          state_next = ST_TAIL;
          cnt_next   = xmem_pkg::TAIL_LOAD;
        end
      end
      ST_TAIL: begin
        if (cnt_zero) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

endmodule

// File: xmem_props.sv
// concurrent checks on the pins and move handshake of the memory interface
// assumes one clock; register writes are one-cycle strobes
`timescale 1ns/1ps
module xmem_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_we,
  input wire logic       xmove_req,
  input wire logic       xmove_busy,
  input wire logic       xmove_done,
  input wire logic       pins_owned,
  input wire logic       addr_hi_oe,
  input wire logic       addr_lo_oe,
  input wire logic       ad_oe,
  input wire logic       ale,
  input wire logic       rd_n,
  input wire logic       wr_n
);
  // ----------------------------------------
  // shadow of the settings and pulse counters
  // ----------------------------------------
  logic [7:0] tim_q;
  logic [7:0] cfg_q;
  logic [4:0] stb_cnt;
  logic [4:0] ale_cnt;
  wire        strobe_on = !rd_n || !wr_n;
  wire        tim_wr    = sfr_we && sfr_addr == xmem_pkg::TIMING_ADDR;
  wire        cfg_wr    = sfr_we && sfr_addr == xmem_pkg::CONFIG_ADDR;
  wire        taken     = xmove_req && !xmove_busy && !xmove_done;
  wire [4:0]  width_exp = {1'b0, tim_q[5:2]} + 5'h01;
  wire [4:0]  ale_exp   = {3'h0, cfg_q[1:0]} + 5'h01;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tim_q <= 8'hff;
      cfg_q <= 8'h03;
      stb_cnt <= 5'h00;
      ale_cnt <= 5'h00;
    end else begin
      if (tim_wr) tim_q <= sfr_wdata;
      if (cfg_wr) cfg_q <= sfr_wdata;
      stb_cnt <= strobe_on ? stb_cnt + 5'h01 : 5'h00;
      ale_cnt <= ale ? ale_cnt + 5'h01 : 5'h00;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_strobe_width: assert property ($rose(!strobe_on) |-> stb_cnt == width_exp)
    else $error("strobe width differs from timing field");
  a_ale_width: assert property ($fell(ale) |-> ale_cnt == ale_exp)
    else $error("latch pulse width differs from config field");
  a_read_release: assert property (!rd_n |-> !ad_oe)
    else $error("data pins driven during read strobe");
  a_write_drive: assert property (!wr_n |-> ad_oe)
    else $error("data pins not driven during write strobe");
  a_strobe_excl: assert property (strobe_on |-> rd_n || wr_n)
    else $error("read and write strobes low together");
  a_owned_only: assert property (!pins_owned |->
    !(addr_hi_oe || addr_lo_oe || ad_oe || ale || strobe_on))
    else $error("pins driven while not owned");
  a_owned_busy: assert property (pins_owned |-> xmove_busy)
    else $error("pins owned without a move");
  a_done_after: assert property ($fell(xmove_busy) |-> xmove_done)
    else $error("busy ended without done");
  a_mux_shared: assert property (ale |-> ad_oe && !addr_lo_oe && !cfg_q[4])
    else $error("latch pulse without low address on shared pins");
  a_nonmux_sep: assert property (pins_owned && cfg_q[4] |-> addr_lo_oe && !ale)
    else $error("separate address pins not used");
  a_onchip_fast: assert property (taken && cfg_q[3:2] == 2'h0 |=> xmove_done && !xmove_busy)
    else $error("internal mode move not done next cycle");
  a_ext_offchip: assert property (taken && cfg_q[3:2] == 2'h3 |=> xmove_busy)
    else $error("external mode move not sent off-chip");
endmodule

bind external_data_memory_interface xmem_props u_props (.clk, .sys_rst, .sfr_addr,
  .sfr_wdata, .sfr_we, .xmove_req, .xmove_busy, .xmove_done, .pins_owned, .addr_hi_oe,
  .addr_lo_oe, .ad_oe, .ale, .rd_n, .wr_n);

// File: xmem_sram_model.sv
// asynchronous byte memory with an address latch on the shared pins
// assumes undriven upper address lines are parked high by port latches
`timescale 1ns/1ps
module xmem_sram_model (
  input wire logic       clk,
  input wire logic [7:0] addr_hi_out,
  input wire logic       addr_hi_oe,
  input wire logic [7:0] addr_lo_out,
  input wire logic       addr_lo_oe,
  input wire logic [7:0] ad_out,
  input wire logic       ad_oe,
  input wire logic       ale,
  input wire logic       rd_n,
  input wire logic       wr_n,
  output logic     [7:0] ad_in
);
  // ----------------------------------------
  // storage and pins
  // ----------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] lat;
  logic [7:0] last;
  wire [15:0] a = {addr_hi_oe ? addr_hi_out : 8'hff, addr_lo_oe ? addr_lo_out : lat};

  // latch holds the low address once ale falls
  // sampled on the clock so that ale falling and the pins turning to
  // data in the same time step cannot race inside the latch
  always @(posedge clk) begin
    if (ale) lat <= ad_out;
  end

  always @(posedge clk) begin
    if (!wr_n && ad_oe) mem[a] <= ad_out;
    if (!rd_n) last <= mem[a];
  end

  // released pins show a changed value, never the stale byte
  assign ad_in = !rd_n ? mem[a] : ~last;
endmodule

// File: tb_top.sv
// self-checking bench for the external data memory interface
// assumes the memory model answers on the pin side
`timescale 1ns/1ps
module tb_top;
  logic        clk, sys_rst, sfr_we, xmove_req, xmove_wr, xmove_is16;
  logic [7:0]  sfr_addr, sfr_wdata, indirect_pointer_register, xmove_wdata;
  logic [15:0] data_pointer, a;
  logic [7:0]  sfr_rdata, xmove_rdata, addr_hi_out, addr_lo_out, ad_out, ad_in;
  logic        xmove_busy, xmove_done, port_select, pins_owned;
  logic        addr_hi_oe, addr_lo_oe, ad_oe, ale, rd_n, wr_n;
  logic [31:0] seed;
  logic [7:0]  got, hi_seen, tim, cfg, d;
  int          fails, tests_run, n_own, n;

  external_data_memory_interface uut (.clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_we,
    .sfr_rdata, .xmove_req, .xmove_wr, .xmove_is16, .data_pointer,
    .indirect_pointer_register, .xmove_wdata, .xmove_busy, .xmove_done, .xmove_rdata,
    .port_select, .pins_owned, .addr_hi_out, .addr_hi_oe, .addr_lo_out, .addr_lo_oe,
    .ad_out, .ad_oe, .ad_in, .ale, .rd_n, .wr_n);
  xmem_sram_model ram (.clk, .addr_hi_out, .addr_hi_oe, .addr_lo_out, .addr_lo_oe,
    .ad_out, .ad_oe, .ale, .rd_n, .wr_n, .ad_in);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int n_exp(input logic [7:0] t, input logic [7:0] c);
    return 5 + t[7:6] + t[5:2] + t[1:0] + (c[4] ? 0 : 2 * (c[1:0] + 1));
  endfunction
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkn(input string nm, input int e, input int g);
    tests_run++;
    if (g != e) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] dt);
    sfr_addr = ad;
    sfr_wdata = dt;
    sfr_we = 1'b1;
    @(posedge clk);
    #1 sfr_we = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic sfr_rd(input logic [7:0] ad);
    sfr_addr = ad;
    repeat (2) @(posedge clk);
    #1 got = sfr_rdata;
  endtask
  // e_own is the expected owned span, zero for an on-chip move
  task automatic move(input logic wr, input logic w16, input logic [15:0] ad,
                      input logic [7:0] dt, input int e_own, input logic e_hi);
    int i;
    if (!w16) sfr_wr(xmem_pkg::PAGE_ADDR, ad[15:8]);
    xmove_wr = wr;
    xmove_is16 = w16;
    data_pointer = ad;
    indirect_pointer_register = ad[7:0];
    xmove_wdata = dt;
    xmove_req = 1'b1;
    n_own = 0;
    hi_seen = 8'h00;
    for (i = 0; i < 100 && xmove_req; i++) begin
      @(posedge clk);
      #1 n_own += pins_owned;
      hi_seen[0] |= addr_hi_oe;
      if (xmove_done === 1'b1) xmove_req = 1'b0;
    end
    // only a timed-out move still holds its request here
    if (xmove_req) xmove_req = 1'b0;
    if (!wr) got = xmove_rdata;
    chkn("move cycles", e_own ? e_own + 2 : 1, i);
    chkn("owned cycles", e_own, n_own);
    chk8("upper drive", {7'h0, e_hi}, hi_seen);
    @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {sys_rst, sfr_we, xmove_req, xmove_wr, xmove_is16} = 5'h10;
    {sfr_addr, sfr_wdata, indirect_pointer_register, xmove_wdata} = 32'h0;
    data_pointer = 16'h0000;
    seed = 32'h47;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    sfr_rd(xmem_pkg::TIMING_ADDR);
    chk8("timing reset", 8'hff, got);
    sfr_rd(xmem_pkg::PAGE_ADDR);
    chk8("page reset", 8'h00, got);
    sfr_rd(xmem_pkg::CONFIG_ADDR);
    chk8("config reset", 8'h03, got);
    sfr_rd(8'ha0);
    chk8("unmapped", 8'h00, got);
    sfr_wr(xmem_pkg::CONFIG_ADDR, 8'hff);
    sfr_rd(xmem_pkg::CONFIG_ADDR);
    chk8("config mask", 8'h3f, got);
    chk8("port select", 8'h01, {7'h0, port_select});
    $display("test registers done");
    sfr_wr(xmem_pkg::CONFIG_ADDR, 8'h10);
    move(1'b1, 1'b1, 16'h1234, 8'h5a, 0, 1'b0);
    move(1'b0, 1'b0, 16'h3234, 8'h00, 0, 1'b0);
    chk8("alias read", 8'h5a, got);
    $display("test internal mode done");
    for (int m = 0; m < 2; m++) begin
      sfr_wr(xmem_pkg::CONFIG_ADDR, m ? 8'h18 : 8'h14);
      sfr_wr(xmem_pkg::TIMING_ADDR, 8'h00);
      move(1'b1, 1'b0, 16'h0a33, 8'h11, 0, 1'b0);
      move(1'b1, 1'b0, 16'h7a33, 8'h22, 5, m[0]);
      move(1'b0, 1'b0, 16'h7a33, 8'h00, 5, m[0]);
      chk8("split read", 8'h22, got);
      move(1'b0, 1'b1, 16'h0a33, 8'h00, 0, 1'b0);
      chk8("on-chip read", 8'h11, got);
      move(1'b0, 1'b1, 16'h1000, 8'h00, 5, 1'b1);
    end
    $display("test split modes done");
    for (int k = 0; k < 12; k++) begin
      seed = xs(seed);
      tim = seed[7:0];
      cfg = k < 6 ? 8'h1c : {6'h0, seed[9:8]} | (k[0] ? 8'h0c : 8'h08);
      if (k % 6 == 0) begin
        tim = 8'h00;
        cfg[1:0] = 2'h0;
      end
      a = seed[31:16] | 16'h1000;
      d = seed[15:8];
      n = n_exp(tim, cfg);
      sfr_wr(xmem_pkg::TIMING_ADDR, tim);
      sfr_wr(xmem_pkg::CONFIG_ADDR, cfg);
      move(1'b1, 1'b1, a, d, n, 1'b1);
      move(1'b1, 1'b1, a ^ 16'h00ff, ~d, n, 1'b1);
      move(1'b0, 1'b1, a, 8'h00, n, 1'b1);
      chk8("round trip", d, got);
      move(1'b1, 1'b0, a, d ^ 8'h3c, n, cfg[3:2] == 2'h2);
      move(1'b0, 1'b0, a, 8'h00, n, cfg[3:2] == 2'h2);
      chk8("byte round trip", d ^ 8'h3c, got);
    end
    $display("test timing and latch done");
    end_of_test();
  end

  // the run needs under 2000 cycles; ten times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule
